/* File: lscomb_top.sv */
// Top of the two-channel loss-of-signal status combiner.
`timescale 1ns/1ps
// Behaviour
// - With its enable set, a channel's loss output is high while any serial input of it reports lost signal, and the enable is off after reset.
// - Each channel's combined loss output and its raw input-loss indication are also offered as readable status outputs for the management interface.
// - With its enable set, loss of channel synchronization is ORed into the loss output, enable cleared at reset.
// - With its enable set, low and high speed PLL loss of lock is ORed into the loss output, enable cleared at reset.
// - With its enable set, any 8b/10b invalid code or disparity error is ORed into the loss output, off at reset.
// - With its enable set, the inverted adaptive gain lock flag is ORed into the loss output, off at reset.
// - With its enable set, the inverted auto-zero done flag is ORed into the loss output, off at reset.
module lscomb_top
   import lscomb_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [LSCOMB_NUM_CHAN*LSCOMB_NUM_LS_LANES-1:0] ls_input_lost,
   input wire logic [LSCOMB_NUM_CHAN-1:0] hs_input_lost,
   input wire logic [LSCOMB_NUM_CHAN-1:0] chan_sync_lost,
   input wire logic [LSCOMB_NUM_CHAN-1:0] ls_pll_unlocked,
   input wire logic [LSCOMB_NUM_CHAN-1:0] hs_pll_unlocked,
   input wire logic [LSCOMB_NUM_CHAN-1:0] dec_invalid_code,
   input wire logic [LSCOMB_NUM_CHAN-1:0] dec_disparity_err,
   input wire logic [LSCOMB_NUM_CHAN-1:0] adaptive_gain_locked,
   input wire logic [LSCOMB_NUM_CHAN-1:0] autozero_cal_done,
   input wire logic [LSCOMB_NUM_CHAN*LSCOMB_NUM_TERMS-1:0] term_enable,
   output logic chan_a_loss_status_out,
   output logic chan_b_loss_status_out,
   output logic [LSCOMB_NUM_CHAN-1:0] loss_status_rd,
   output logic [LSCOMB_NUM_CHAN-1:0] raw_input_lost_rd
);
   // Analog detector flags come from outside the clock domain and are synchronised.
   localparam int NRAW = LSCOMB_NUM_CHAN*(LSCOMB_NUM_LS_LANES+1);
   localparam int NSYN = NRAW + 7*LSCOMB_NUM_CHAN;
   logic [NSYN-1:0] async_in;
   logic [NSYN-1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
   logic [NSYN-1:0] stable_q, stable_d;
   logic [LSCOMB_NUM_CHAN*LSCOMB_NUM_TERMS-1:0] en_q, en_d;
   logic [LSCOMB_NUM_CHAN-1:0] loss_int;
   logic [LSCOMB_NUM_CHAN-1:0] raw_d, raw_q;
   logic [LSCOMB_NUM_CHAN-1:0] rd_q;

   // A synchronised bit takes a new value only once the second and third stages agree.
   // This filters one-cycle glitches on the analog detectors at the cost of one more edge.
   assign async_in = {autozero_cal_done, adaptive_gain_locked, dec_disparity_err,
      dec_invalid_code, hs_pll_unlocked, ls_pll_unlocked, chan_sync_lost,
      hs_input_lost, ls_input_lost};

   always_comb
   begin
      s1_d = async_in;
      s2_d = s1_q;
      s3_d = s2_q;
      stable_d = stable_q;
      for (int i = 0; i < NSYN; i++)
      begin
         if (s2_q[i] == s3_q[i])
         begin
            stable_d[i] = s3_q[i];
         end
      end
      en_d = term_enable;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         stable_q <= '0;
         en_q <= {LSCOMB_NUM_CHAN{LSCOMB_EN_RESET}};
      end
      else
      begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         stable_q <= stable_d;
         en_q <= en_d;
      end
   end

   genvar c;
   generate
      for (c = 0; c < LSCOMB_NUM_CHAN; c++)
      begin : g_chan
         lscomb_chan_if cif ();
         localparam int B = NRAW;
         localparam int N = LSCOMB_NUM_CHAN;
         always_comb
         begin
            raw_d[c] = (|stable_q[c*LSCOMB_NUM_LS_LANES +: LSCOMB_NUM_LS_LANES])
               | stable_q[LSCOMB_NUM_CHAN*LSCOMB_NUM_LS_LANES + c];
            cif.cond[LSCOMB_TERM_RAW] = raw_d[c];
            cif.cond[LSCOMB_TERM_SYNC] = stable_q[B + c];
            cif.cond[LSCOMB_TERM_PLL] = stable_q[B + N + c] | stable_q[B + 2*N + c];
            cif.cond[LSCOMB_TERM_DEC] = stable_q[B + 3*N + c] | stable_q[B + 4*N + c];
            cif.cond[LSCOMB_TERM_AGC] = ~stable_q[B + 5*N + c];
            cif.cond[LSCOMB_TERM_AZ] = ~stable_q[B + 6*N + c];
            cif.en = en_q[c*LSCOMB_NUM_TERMS +: LSCOMB_NUM_TERMS];
         end
         lscomb_chan u_chan (
            .clock(clock),
            .rst(rst),
            .chan(cif.dst),
            .loss_q(loss_int[c])
         );

         // An enabled term that holds at one edge must show on the readable status two edges
         // later: one edge in the channel register and one in the output register.
         sequence s_raw_hit;
            en_q[c*LSCOMB_NUM_TERMS + LSCOMB_TERM_RAW] && raw_d[c];
         endsequence

         sequence s_sync_hit;
            en_q[c*LSCOMB_NUM_TERMS + LSCOMB_TERM_SYNC] && stable_q[B + c];
         endsequence

         sequence s_pll_hit;
            en_q[c*LSCOMB_NUM_TERMS + LSCOMB_TERM_PLL] && (stable_q[B + N + c] || stable_q[B + 2*N + c]);
         endsequence

         sequence s_dec_hit;
            en_q[c*LSCOMB_NUM_TERMS + LSCOMB_TERM_DEC]
               && (stable_q[B + 3*N + c] || stable_q[B + 4*N + c]);
         endsequence

         sequence s_agc_hit;
            en_q[c*LSCOMB_NUM_TERMS + LSCOMB_TERM_AGC] && !stable_q[B + 5*N + c];
         endsequence

         sequence s_az_hit;
            en_q[c*LSCOMB_NUM_TERMS + LSCOMB_TERM_AZ] && !stable_q[B + 6*N + c];
         endsequence

         sequence s_all_off;
            (en_q[c*LSCOMB_NUM_TERMS +: LSCOMB_NUM_TERMS] == '0) [*2];
         endsequence

         a_raw_loss_rd: assert property (@(posedge clock) disable iff (rst)
            s_raw_hit
            |=> ##1 loss_status_rd[c])
            else $error("Raw input loss did not raise the readable status.");

         a_sync_loss_rd: assert property (@(posedge clock) disable iff (rst)
            s_sync_hit
            |=> ##1 loss_status_rd[c])
            else $error("Channel sync loss did not raise the readable status.");

         a_pll_loss_rd: assert property (@(posedge clock) disable iff (rst)
            s_pll_hit
            |=> ##1 loss_status_rd[c])
            else $error("PLL unlock did not raise the readable status.");

         a_dec_loss_rd: assert property (@(posedge clock) disable iff (rst)
            s_dec_hit
            |=> ##1 loss_status_rd[c])
            else $error("Decode error did not raise the readable status.");

         a_agc_loss_rd: assert property (@(posedge clock) disable iff (rst)
            s_agc_hit
            |=> ##1 loss_status_rd[c])
            else $error("Gain unlock did not raise the readable status.");

         a_az_loss_rd: assert property (@(posedge clock) disable iff (rst)
            s_az_hit
            |=> ##1 loss_status_rd[c])
            else $error("Auto-zero not done did not raise the readable status.");

         a_quiet_when_off: assert property (@(posedge clock) disable iff (rst)
            s_all_off
            |=> !loss_status_rd[c])
            else $error("Readable status high with every term disabled.");

         a_raw_readback: assert property (@(posedge clock) disable iff (rst)
            ##1 (raw_input_lost_rd[c] == $past(raw_d[c])))
            else $error("Raw loss readback does not follow the lane detectors.");
      end
   endgenerate

   // Pins and readback are loaded from the same level, so they can never disagree.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         chan_a_loss_status_out <= 1'b0;
         chan_b_loss_status_out <= 1'b0;
         rd_q <= '0;
         raw_q <= '0;
      end
      else
      begin
         chan_a_loss_status_out <= loss_int[0];
         chan_b_loss_status_out <= loss_int[1];
         rd_q <= loss_int;
         raw_q <= raw_d;
      end
   end

   assign loss_status_rd = rd_q;
   assign raw_input_lost_rd = raw_q;

   // The enables pass one register, so an enable change reaches the pins after three edges.
   a_enable_capture: assert property (@(posedge clock) disable iff (rst)
      ##1 (en_q == $past(term_enable)))
      else $error("Enable register does not follow the enable inputs.");

   a_sync_agree: assert property (@(posedge clock) disable iff (rst)
      (s2_q == s3_q)
      |=> (stable_q == $past(s3_q)))
      else $error("Agreed synchroniser value was not taken.");

   a_pins_match_read: assert property (@(posedge clock) disable iff (rst)
      (chan_a_loss_status_out == loss_status_rd[0]) && (chan_b_loss_status_out == loss_status_rd[1]))
      else $error("Status pins disagree with readable status.");

   a_disabled_stays_low: assert property (@(posedge clock) disable iff (rst)
      (en_q[LSCOMB_NUM_TERMS-1:0] == '0) [*2] |=> !chan_a_loss_status_out)
      else $error("Channel A loss high with all terms disabled.");

   a_agc_unlock_loss: assert property (@(posedge clock) disable iff (rst)
      (en_q[LSCOMB_TERM_AGC] && !stable_q[NRAW + 5*LSCOMB_NUM_CHAN]) |=> ##1 chan_a_loss_status_out)
      else $error("Gain unlock did not raise channel A loss.");

   a_az_undone_loss: assert property (@(posedge clock) disable iff (rst)
      (en_q[LSCOMB_NUM_TERMS + LSCOMB_TERM_AZ] && !stable_q[NRAW + 6*LSCOMB_NUM_CHAN + 1])
      |=> ##1 chan_b_loss_status_out)
      else $error("Auto-zero not done did not raise channel B loss.");
endmodule

/* File: lscomb_pkg.sv */
// Package with constants and types for the loss-of-signal status combiner.
package lscomb_pkg;
   localparam int LSCOMB_NUM_CHAN = 2;
   localparam int LSCOMB_NUM_LS_LANES = 4;
   localparam int LSCOMB_SYNC_DEPTH = 3;
   localparam int LSCOMB_NUM_TERMS = 6;
   localparam int LSCOMB_TERM_RAW = 0;
   localparam int LSCOMB_TERM_SYNC = 1;
   localparam int LSCOMB_TERM_PLL = 2;
   localparam int LSCOMB_TERM_DEC = 3;
   localparam int LSCOMB_TERM_AGC = 4;
   localparam int LSCOMB_TERM_AZ = 5;
   localparam logic [LSCOMB_NUM_TERMS-1:0] LSCOMB_EN_RESET = 6'h00;
   typedef logic [LSCOMB_NUM_TERMS-1:0] lscomb_terms_t;
endpackage

/* File: lscomb_chan_if.sv */
// Interface carrying one channel's qualified loss terms to its combiner.
`timescale 1ns/1ps
interface lscomb_chan_if;
   import lscomb_pkg::*;
   lscomb_terms_t cond;
   lscomb_terms_t en;
   modport src (output cond, output en);
   modport dst (input cond, input en);
endinterface

/* File: lscomb_chan.sv */
// One channel's loss combiner: gate each term by its enable and register the OR.
`timescale 1ns/1ps
module lscomb_chan
   import lscomb_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   lscomb_chan_if.dst chan,
   output logic loss_q
);
   logic loss_d;
   lscomb_terms_t gated;

   always_comb
   begin
      gated = chan.cond & chan.en;
      loss_d = |gated;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         loss_q <= 1'b0;
      end
      else
      begin
         loss_q <= loss_d;
      end
   end

   a_loss_follows_terms: assert property (@(posedge clock) disable iff (rst)
      ##1 (loss_q == $past(|(chan.cond & chan.en))))
      else $error("Loss output does not follow gated terms.");
endmodule

/* File: lscomb_mon.sv */
// Partner model: system logic counting loss events seen on the status pins.
`timescale 1ns/1ps
module lscomb_mon
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [1:0] loss,
   output logic [7:0] rises_q
);
   logic [1:0] loss_q;
   logic [7:0] rises_d;
   always_comb
   begin
      rises_d = rises_q + 8'(loss[0] & ~loss_q[0]) + 8'(loss[1] & ~loss_q[1]);
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         loss_q <= 2'h0;
         rises_q <= 8'h00;
      end
      else
      begin
         loss_q <= loss;
         rises_q <= rises_d;
      end
   end
endmodule

/* File: test_loss_of_signal_status_combiner.sv */
// Testbench for the two-channel loss-of-signal status combiner.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module test_loss_of_signal_status_combiner;
   import lscomb_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] ls_lost = 8'h00;
   logic [15:0] cnd = 16'hF000;
   logic [11:0] ten = 12'h000;
   logic [1:0] outs, rd, raw_rd;
   logic [7:0] rises;
   int n_checks = 0;
   int n_mismatch = 0;
   int cyc = 0;
   int pos[7] = '{2, 4, 6, 8, 10, 12, 14};
   int trm[7] = '{1, 2, 2, 3, 3, 4, 5};
   lscomb_top lscomb_top_inst (.clock(clock), .rst(rst), .ls_input_lost(ls_lost),
      .hs_input_lost(cnd[1:0]), .chan_sync_lost(cnd[3:2]), .ls_pll_unlocked(cnd[5:4]),
      .hs_pll_unlocked(cnd[7:6]), .dec_invalid_code(cnd[9:8]),
      .dec_disparity_err(cnd[11:10]), .adaptive_gain_locked(cnd[13:12]),
      .autozero_cal_done(cnd[15:14]), .term_enable(ten),
      .chan_a_loss_status_out(outs[0]), .chan_b_loss_status_out(outs[1]),
      .loss_status_rd(rd), .raw_input_lost_rd(raw_rd));
   lscomb_mon lscomb_mon_inst (.clock(clock), .rst(rst), .loss(outs), .rises_q(rises));
   initial
   begin
      forever #20 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         results();
      end
   end
   task results;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task w8;
      repeat (8) @(negedge clock);
   endtask
   task t_reset;
      cnd = 16'hF003;
      ten = 12'hFFF;
      repeat (10) @(negedge clock);
      `CHK({outs, rd, raw_rd}, 6'h00)
      ten = 12'h000;
      repeat (10) @(negedge clock);
      rst = 1'b0;
      w8();
      `CHK({outs, rd}, 4'h0)
      `CHK(raw_rd, 2'h3)
      cnd = 16'hF000;
      w8();
   endtask
   task t_raw;
      for (int c = 0; c < 2; c++)
         for (int l = 0; l < 5; l++)
         begin
            if (l < 4)
               ls_lost[4 * c + l] = 1'b1;
            else
               cnd[c] = 1'b1;
            ten[6 * c] = 1'b1;
            w8();
            `CHK(outs, 2'(1 << c))
            `CHK({rd, raw_rd}, {2'(1 << c), 2'(1 << c)})
            ls_lost = 8'h00;
            cnd = 16'hF000;
            w8();
            `CHK(outs, 2'h0)
            ten = 12'h000;
         end
      `CHK(rises, 8'h0A)
   endtask
   task t_terms;
      for (int c = 0; c < 2; c++)
         for (int i = 0; i < 7; i++)
         begin
            cnd = cnd ^ (16'h1 << (pos[i] + c));
            ten = (12'h03F << (6 * c)) ^ (12'h001 << (6 * c + trm[i]));
            w8();
            `CHK({outs, rd}, 4'h0)
            ten = 12'h001 << (6 * c + trm[i]);
            w8();
            `CHK({outs, rd}, {2'(1 << c), 2'(1 << c)})
            cnd = 16'hF000;
            w8();
            `CHK(outs, 2'h0)
            ten = 12'h000;
         end
      `CHK(rises, 8'h18)
   endtask
   initial
   begin
      t_reset();
      t_raw();
      t_terms();
      results();
   end
endmodule
